// [hw/cpr_consts.svh]
// cpr_consts.svh: named positions, masks, reset values and steps
// assumes: included by the package and every design file of the block
`ifndef CPR_CONSTS_SVH
`define CPR_CONSTS_SVH
`define CPR_GPR_N        8
`define CPR_SP_IDX       3'h7
`define CPR_PC_W         24
`define CPR_CCR_RESET    8'h80
`define CPR_MSB_BYTE     7
`define CPR_MSB_WORD     15
`define CPR_MSB_LONG     31
`define CPR_HC_BYTE      3
`define CPR_HC_WORD      11
`define CPR_HC_LONG      27
`define CPR_MASK_BYTE    32'h000000FF
`define CPR_MASK_WORD    32'h0000FFFF
`define CPR_MASK_LONG    32'hFFFFFFFF
`define CPR_SIGN_BYTE    32'h00000080
`define CPR_SIGN_WORD    32'h00008000
`define CPR_SIGN_LONG    32'h80000000
`define CPR_AMASK_NORMAL 24'h00FFFF
`define CPR_AMASK_1M     24'h0FFFFF
`define CPR_AMASK_16M    24'hFFFFFF
`define CPR_STEP_WORD    32'h00000002
`define CPR_STEP_LONG    32'h00000004
`define CPR_BCD_MAX      4'h9
`define CPR_BCD_BYTE_MAX 8'h99
`define CPR_BCD_ADJ_LO   8'h06
`define CPR_BCD_ADJ_HI   8'h60
`endif

// [hw/cpr_pkg.sv]
// cpr_pkg: types and size helpers of the cpu state block
// assumes: cpr_consts.svh is on the include path
`include "cpr_consts.svh"
package cpr_pkg;
  typedef enum logic [1:0] {
    sz_byte = 2'b00, sz_word = 2'b01, sz_long = 2'b10
  } cpr_size_t;
  typedef enum logic [1:0] {
    md_normal = 2'b00, md_adv_1m = 2'b01, md_adv_16m = 2'b10
  } cpr_mode_t;
  typedef enum logic [1:0] {
    sp_none = 2'b00, sp_push = 2'b01, sp_pop = 2'b10
  } cpr_sp_op_t;
  typedef enum logic [4:0] {
    op_nop = 5'b00000, op_add = 5'b00001, op_addx = 5'b00010,
    op_sub = 5'b00011, op_subx = 5'b00100, op_cmp = 5'b00101,
    op_neg = 5'b00110, op_and = 5'b00111, op_or = 5'b01000,
    op_xor = 5'b01001, op_mov = 5'b01010, op_shll = 5'b01011,
    op_shlr = 5'b01100, op_rotl = 5'b01101, op_rotr = 5'b01110,
    op_daa = 5'b01111, op_das = 5'b10000, op_ldc = 5'b10001,
    op_and_flags_instr = 5'b10010, op_orc = 5'b10011, op_xor_flags_instr = 5'b10100,
    op_bit_load = 5'b10101, op_bit_and = 5'b10110,
    op_bit_or = 5'b10111, op_bit_xor = 5'b11000,
    op_bit_store = 5'b11001, op_bit_set = 5'b11010,
    op_bit_clr = 5'b11011, op_bit_not = 5'b11100,
    op_bit_test = 5'b11101
  } cpr_op_t;
  // upper: word selects the extended half, byte selects the high byte
  typedef struct packed {
    logic [2:0] idx;
    cpr_size_t  size;
    logic       upper;
  } cpr_sel_t;
  typedef struct packed {
    logic i; logic ui; logic h; logic u;
    logic n; logic z; logic v; logic c;
  } cpr_flags_t;
  typedef struct packed {
    logic        valid;
    cpr_op_t     op;
    cpr_size_t   size;
    logic [31:0] a;
    logic [31:0] b;
    logic [2:0]  bit_num;
    logic        inv;
    logic        wb;
    cpr_sel_t    dst;
  } cpr_alu_req_t;
  function automatic logic [31:0] cpr_size_mask(input cpr_size_t s);
    case (s)
      sz_byte: return `CPR_MASK_BYTE;
      sz_word: return `CPR_MASK_WORD;
      default: return `CPR_MASK_LONG;
    endcase
  endfunction : cpr_size_mask
  function automatic logic [31:0] cpr_sign_bit(input cpr_size_t s);
    case (s)
      sz_byte: return `CPR_SIGN_BYTE;
      sz_word: return `CPR_SIGN_WORD;
      default: return `CPR_SIGN_LONG;
    endcase
  endfunction : cpr_sign_bit
endpackage : cpr_pkg

// [hw/cpr_flag_alu.sv]
// cpr_flag_alu: add/subtract core with carry, half-carry and overflow
// assumes: operands arrive zero-extended above the operand size
`timescale 1ns/100ps
`include "cpr_consts.svh"
module cpr_flag_alu (
  input  cpr_pkg::cpr_size_t size,
  input  wire logic          sub,
  input  wire logic          ext,
  input  wire logic          c_in,
  input  wire logic [31:0]   a,
  input  wire logic [31:0]   b,
  output logic [31:0]        sum,
  output logic               c_out,
  output logic               h_out,
  output logic               v_out
);
  import cpr_pkg::*;
  logic [32:0] a_ext;
  logic [32:0] b_ext;
  logic [32:0] full;
  logic [32:0] cy;
  logic        cin;
  logic        c_msb;
  logic        c_top;
  logic        c_half;
  assign a_ext = {1'b0, a};
  assign b_ext = {1'b0, sub ? ~b & cpr_size_mask(size) : b};
  // extend variants fold the old carry in; subtract inverts it
  assign cin   = sub ? ~(ext & c_in) : (ext & c_in);
  assign full  = a_ext + b_ext + {32'h0, cin};
  // carry into each bit position, recovered from the sum
  assign cy    = full ^ a_ext ^ b_ext;
  assign c_top = (size == sz_byte) ? cy[`CPR_MSB_BYTE + 1] :
                 (size == sz_word) ? cy[`CPR_MSB_WORD + 1] :
                 cy[`CPR_MSB_LONG + 1];
  assign c_msb = (size == sz_byte) ? cy[`CPR_MSB_BYTE] :
                 (size == sz_word) ? cy[`CPR_MSB_WORD] :
                 cy[`CPR_MSB_LONG];
  assign c_half = (size == sz_byte) ? cy[`CPR_HC_BYTE + 1] :
                  (size == sz_word) ? cy[`CPR_HC_WORD + 1] :
                  cy[`CPR_HC_LONG + 1];
  assign sum   = full[31:0] & cpr_size_mask(size);
  // borrow is the inverted carry on subtraction
  assign c_out = sub ? ~c_top : c_top;
  assign h_out = sub ? ~c_half : c_half;
  assign v_out = c_top ^ c_msb;
endmodule : cpr_flag_alu

// [hw/cpr_addr_unit.sv]
// cpr_addr_unit: aligns and truncates an effective address
// assumes: mode is already synchronised to the core clock
`timescale 1ns/100ps
`include "cpr_consts.svh"
module cpr_addr_unit (
  input  wire logic [23:0]   ea,
  input  cpr_pkg::cpr_size_t size,
  input  cpr_pkg::cpr_mode_t mode,
  input  wire logic          fetch,
  output logic [23:0]        addr
);
  import cpr_pkg::*;
  logic [23:0] aligned;
  logic [23:0] amask;
  assign aligned = (fetch || size != sz_byte) ? {ea[23:1], 1'b0} : ea;
  assign amask   = (mode == md_normal) ? `CPR_AMASK_NORMAL :
                   (mode == md_adv_1m) ? `CPR_AMASK_1M : `CPR_AMASK_16M;
  assign addr    = aligned & amask;
endmodule : cpr_addr_unit

// [hw/cpr_regfile.sv]
// cpr_regfile: general registers, stack pointer, program counter and
// condition flags of the cpu, with the flag-producing operations
// assumes: the instruction datapath drives requests on core_clk and
// keeps at most one write per register per cycle
// How it works
// - eight 32-bit registers, long/word/byte access
// - each splits into extended and low halves
// - low half splits into high and low bytes
// - register seven doubles as stack pointer
// - 24-bit program counter, fetch bit zero cleared
// - eight flag bits at fixed positions
// - mask bit blocks interrupts, set on exceptions
// - bits six and four freely software writable
// - half-carry from bit 3, 11 or 27
// - negative takes the result sign bit
// - zero flag set on zero result
// - overflow set on overflow, else cleared
// - carry from add, borrow, shifted-out bit
// - carry acts as one-bit accumulator
// - branches test flags; others keep unchanged
// - reset loads vector, sets mask bit only
// - odd word addresses silently rounded down
// - 1-Mbyte mode drops top four address bits
// - normal 64 kbytes, advanced 16 Mbytes
// - bit ops pick bit 0-7; bcd adjust
`timescale 1ns/100ps
`include "cpr_consts.svh"
module cpr_regfile #(
  parameter int GPR_N = `CPR_GPR_N
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  cpr_pkg::cpr_mode_t    cpu_mode,
  input  wire logic             reset_exc,
  input  wire logic [23:0]      reset_vector,
  input  wire logic             exc_start,
  input  wire logic             pc_load,
  input  wire logic [23:0]      pc_target,
  input  wire logic             pc_inc,
  input  wire logic [3:0]       pc_step,
  input  wire logic             wr_en,
  input  cpr_pkg::cpr_sel_t     wr_sel,
  input  wire logic [31:0]      wr_data,
  input  cpr_pkg::cpr_sel_t     rd_sel,
  input  cpr_pkg::cpr_alu_req_t alu_req,
  input  cpr_pkg::cpr_sp_op_t   sp_op,
  input  cpr_pkg::cpr_size_t    sp_size,
  input  wire logic [3:0]       br_cond,
  input  wire logic [23:0]      ea,
  input  cpr_pkg::cpr_size_t    ea_size,
  output logic [31:0]           rd_data,
  output logic [31:0]           alu_result,
  output logic                  alu_done,
  output logic [23:0]           stack_addr,
  output logic [23:0]           program_counter,
  output logic [23:0]           fetch_addr,
  output logic [23:0]           data_addr,
  output cpr_pkg::cpr_flags_t   condition_flags,
  output logic                  branch_true
);
  import cpr_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input cpr_sel_t s,
                                        input logic [31:0] d);
    case (s.size)
      sz_long: return d;
      sz_word: return s.upper ? {d[15:0], old[15:0]}
                              : {old[31:16], d[15:0]};
      default: return s.upper ? {old[31:16], d[7:0], old[7:0]}
                              : {old[31:8], d[7:0]};
    endcase
  endfunction : merge

  function automatic logic [31:0] extract(input logic [31:0] q,
                                          input cpr_sel_t s);
    case (s.size)
      sz_long: return q;
      sz_word: return s.upper ? {16'h0000, q[31:16]}
                              : {16'h0000, q[15:0]};
      default: return s.upper ? {24'h000000, q[15:8]}
                              : {24'h000000, q[7:0]};
    endcase
  endfunction : extract

  // branch condition on n, z, v, c
  function automatic logic cond_true(input logic [3:0] cc,
                                     input cpr_flags_t f);
    case (cc)
      4'h0: return 1'b1;
      4'h1: return 1'b0;
      4'h2: return ~(f.c | f.z);
      4'h3: return f.c | f.z;
      4'h4: return ~f.c;
      4'h5: return f.c;
      4'h6: return ~f.z;
      4'h7: return f.z;
      4'h8: return ~f.v;
      4'h9: return f.v;
      4'hA: return ~f.n;
      4'hB: return f.n;
      4'hC: return ~(f.n ^ f.v);
      4'hD: return f.n ^ f.v;
      4'hE: return ~(f.z | (f.n ^ f.v));
      default: return f.z | (f.n ^ f.v);
    endcase
  endfunction : cond_true

  logic [31:0] gpr [GPR_N];
  cpr_mode_t   mode_meta;
  cpr_mode_t   mode_sync;
  logic [23:0] next_pc;
  logic [23:0] next_fetch;
  logic [23:0] next_data;
  logic [31:0] sp_step;
  logic [31:0] next_sp;
  logic        sp_act;
  logic        alu_wr;
  cpr_flags_t  next_flags;
  cpr_flags_t  alu_flags;
  logic [31:0] alu_res;

  // cpu mode strap crosses in through two flops
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_meta <= md_adv_16m;
      mode_sync <= md_adv_16m;
    end else begin
      mode_meta <= cpu_mode;
      mode_sync <= mode_meta;
    end
  end

  // ---- general registers ----
  assign alu_wr = alu_req.valid && alu_req.wb;
  assign sp_act = (sp_op != sp_none);
  assign sp_step = (sp_size == sz_long) ? `CPR_STEP_LONG
                                        : `CPR_STEP_WORD;
  assign next_sp = (sp_op == sp_push) ? gpr[`CPR_SP_IDX] - sp_step
                                      : gpr[`CPR_SP_IDX] + sp_step;

  // contents are left uninitialised by reset
  generate
    for (genvar g = 0; g < GPR_N; g++) begin : g_gpr
      always_ff @(posedge core_clk) begin
        if (alu_wr && alu_req.dst.idx == 3'(g)) begin
          gpr[g] <= merge(gpr[g], alu_req.dst, alu_res);
        end else if (wr_en && wr_sel.idx == 3'(g)) begin
          gpr[g] <= merge(gpr[g], wr_sel, wr_data);
        end else if (sp_act && 3'(g) == `CPR_SP_IDX) begin
          gpr[g] <= next_sp;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data    <= 32'h00000000;
      stack_addr <= 24'h000000;
    end else begin
      rd_data <= extract(gpr[rd_sel.idx], rd_sel);
      if (sp_act) begin
        stack_addr <= (sp_op == sp_push) ? next_sp[23:0]
                                         : gpr[`CPR_SP_IDX][23:0];
      end
    end
  end

  // ---- program counter and addresses ----
  // reset vector load
  assign next_pc = reset_exc ? reset_vector :
                   pc_load   ? pc_target :
                   pc_inc    ? program_counter + {20'h00000, pc_step} :
                   program_counter;

  cpr_addr_unit u_fetch_addr (
    .ea   (next_pc),
    .size (sz_word),
    .mode (mode_sync),
    .fetch(1'b1),
    .addr (next_fetch)
  );

  cpr_addr_unit u_data_addr (
    .ea   (ea),
    .size (ea_size),
    .mode (mode_sync),
    .fetch(1'b0),
    .addr (next_data)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      program_counter <= 24'h000000;
      fetch_addr      <= 24'h000000;
      data_addr       <= 24'h000000;
    end else begin
      program_counter <= next_pc;
      fetch_addr      <= next_fetch;
      data_addr       <= next_data;
    end
  end

  // ---- flag-producing operations ----
  logic [31:0] mask;
  logic [31:0] sign;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [31:0] bit_hot;
  logic        bit_val;
  logic        acc_bit;
  logic        is_sub;
  logic        is_ext;
  logic [31:0] ar_a;
  logic [31:0] ar_b;
  logic [31:0] ar_sum;
  logic        ar_c;
  logic        ar_h;
  logic        ar_v;
  logic        lo_adj;
  logic        hi_adj;
  logic [7:0]  daa_adj;
  logic [7:0]  das_adj;
  logic        nz_upd;
  logic [31:0] res_m;

  assign mask    = cpr_size_mask(alu_req.size);
  assign sign    = cpr_sign_bit(alu_req.size);
  assign opa     = alu_req.a & mask;
  assign opb     = alu_req.b & mask;
  // bit number picks one bit of a byte
  assign bit_hot = {24'h000000, 8'h01 << alu_req.bit_num};
  assign bit_val = (|(opa & bit_hot)) ^ alu_req.inv;
  assign acc_bit = condition_flags.c ^ alu_req.inv;
  assign is_sub  = (alu_req.op == op_sub) || (alu_req.op == op_subx) ||
                   (alu_req.op == op_cmp) || (alu_req.op == op_neg);
  assign is_ext  = (alu_req.op == op_addx) || (alu_req.op == op_subx);
  assign ar_a    = (alu_req.op == op_neg) ? 32'h00000000 : opa;
  assign ar_b    = (alu_req.op == op_neg) ? opa : opb;

  assign lo_adj  = (opa[3:0] > `CPR_BCD_MAX) || condition_flags.h;
  assign hi_adj  = (opa[7:0] > `CPR_BCD_BYTE_MAX) || condition_flags.c;
  assign daa_adj = (lo_adj ? `CPR_BCD_ADJ_LO : 8'h00) +
                   (hi_adj ? `CPR_BCD_ADJ_HI : 8'h00);
  assign das_adj = (condition_flags.h ? `CPR_BCD_ADJ_LO : 8'h00) +
                   (condition_flags.c ? `CPR_BCD_ADJ_HI : 8'h00);

  cpr_flag_alu u_arith (
    .size (alu_req.size),
    .sub  (is_sub),
    .ext  (is_ext),
    .c_in (condition_flags.c),
    .a    (ar_a),
    .b    (ar_b),
    .sum  (ar_sum),
    .c_out(ar_c),
    .h_out(ar_h),
    .v_out(ar_v)
  );

  always_comb begin
    alu_res   = opa;
    alu_flags = condition_flags;
    nz_upd    = 1'b0;
    case (alu_req.op)
      op_add, op_addx, op_sub, op_subx, op_cmp, op_neg: begin
        alu_res     = ar_sum;
        alu_flags.h = ar_h;
        alu_flags.v = ar_v;
        alu_flags.c = ar_c;
        nz_upd      = 1'b1;
      end
      op_and, op_or, op_xor, op_mov: begin
        alu_res = (alu_req.op == op_and) ? opa & opb :
                  (alu_req.op == op_or)  ? opa | opb :
                  (alu_req.op == op_xor) ? opa ^ opb : opb;
        alu_flags.v = 1'b0;
        nz_upd      = 1'b1;
      end
      op_shll, op_rotl: begin
        alu_res     = (opa << 1) |
                      ((alu_req.op == op_rotl && |(opa & sign))
                       ? 32'h00000001 : 32'h00000000);
        alu_flags.c = |(opa & sign);
        alu_flags.v = 1'b0;
        nz_upd      = 1'b1;
      end
      op_shlr, op_rotr: begin
        alu_res     = (opa >> 1) |
                      ((alu_req.op == op_rotr && opa[0]) ? sign
                                                         : 32'h00000000);
        alu_flags.c = opa[0];
        alu_flags.v = 1'b0;
        nz_upd      = 1'b1;
      end
      op_daa: begin
        alu_res     = {24'h000000, opa[7:0] + daa_adj};
        alu_flags.c = hi_adj;
        nz_upd      = 1'b1;
      end
      op_das: begin
        alu_res = {24'h000000, opa[7:0] - das_adj};
        nz_upd  = 1'b1;
      end
      // software access to all flag bits
      op_ldc:  alu_flags = cpr_flags_t'(opa[7:0]);
      op_and_flags_instr: alu_flags = condition_flags & cpr_flags_t'(opa[7:0]);
      op_orc:  alu_flags = condition_flags | cpr_flags_t'(opa[7:0]);
      op_xor_flags_instr: alu_flags = condition_flags ^ cpr_flags_t'(opa[7:0]);
      op_bit_load: alu_flags.c = bit_val;
      op_bit_and:  alu_flags.c = condition_flags.c & bit_val;
      op_bit_or:   alu_flags.c = condition_flags.c | bit_val;
      op_bit_xor:  alu_flags.c = condition_flags.c ^ bit_val;
      op_bit_store: alu_res = acc_bit ? (opa | bit_hot)
                                      : (opa & ~bit_hot);
      op_bit_set:  alu_res = opa | bit_hot;
      op_bit_clr:  alu_res = opa & ~bit_hot;
      op_bit_not:  alu_res = opa ^ bit_hot;
      op_bit_test: alu_flags.z = ~bit_val;
      default: alu_res = opa;
    endcase
    // sign of result at operand size
    if (nz_upd) begin
      alu_flags.n = |(alu_res & sign);
      alu_flags.z = ~|(alu_res & mask);
    end
  end

  assign res_m = alu_res & mask;

  // flags change only on flag ops, and exceptions set the mask bit
  always_comb begin
    next_flags = alu_req.valid ? alu_flags : condition_flags;
    // mask set wins over any write
    if (exc_start || reset_exc) begin
      next_flags.i = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      condition_flags <= cpr_flags_t'(`CPR_CCR_RESET);
      alu_result      <= 32'h00000000;
      alu_done        <= 1'b0;
      branch_true     <= 1'b0;
    end else begin
      condition_flags <= next_flags;
      alu_result      <= res_m;
      alu_done        <= alu_req.valid;
      branch_true     <= cond_true(br_cond, condition_flags);
    end
  end

  // ---- checks ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_plain_wr(cpr_size_t sz, logic up);
    wr_en && wr_sel.size == sz && wr_sel.upper == up && !alu_wr &&
    !(sp_act && wr_sel.idx == `CPR_SP_IDX);
  endsequence

  sequence s_push_long;
    sp_op == sp_push && sp_size == sz_long && !alu_wr && !wr_en;
  endsequence

  gpr_long_wr_a: assert property (
    s_plain_wr(sz_long, 1'b0) |=> gpr[$past(wr_sel.idx)] == $past(wr_data))
    else $error("long register write lost");
  word_upper_a: assert property (
    s_plain_wr(sz_word, 1'b1) |=>
      gpr[$past(wr_sel.idx)][31:16] == $past(wr_data[15:0]) &&
      gpr[$past(wr_sel.idx)][15:0] == $past(gpr[wr_sel.idx][15:0]))
    else $error("extended half write disturbs low half");
  byte_high_a: assert property (
    s_plain_wr(sz_byte, 1'b1) |=>
      gpr[$past(wr_sel.idx)][15:8] == $past(wr_data[7:0]) &&
      gpr[$past(wr_sel.idx)][7:0] == $past(gpr[wr_sel.idx][7:0]))
    else $error("high byte write wrong");
  sp_push_a: assert property (
    s_push_long |=> gpr[`CPR_SP_IDX] ==
      $past(gpr[`CPR_SP_IDX]) - `CPR_STEP_LONG &&
      stack_addr == gpr[`CPR_SP_IDX][23:0])
    else $error("stack push step wrong");
  fetch_even_a: assert property (
    fetch_addr[0] == 1'b0 && (mode_sync != md_adv_16m ||
      fetch_addr[23:1] == program_counter[23:1]))
    else $error("fetch address not even");
  exc_mask_a: assert property (
    exc_start |=> condition_flags.i)
    else $error("mask bit not set on exception");
  reset_vec_a: assert property (
    reset_exc |=> program_counter == $past(reset_vector) &&
      condition_flags.i)
    else $error("reset exception load wrong");
  add_zero_a: assert property (
    alu_req.valid && alu_req.op == op_add |=>
      condition_flags.z == (alu_result == 32'h00000000))
    else $error("zero flag disagrees with result");
  nop_keep_a: assert property (
    alu_req.valid && alu_req.op == op_nop && !exc_start && !reset_exc
      |=> condition_flags == $past(condition_flags))
    else $error("flags changed by no-op");
  data_even_a: assert property (
    ea_size != sz_byte |=> data_addr[0] == 1'b0)
    else $error("word access address odd");
  one_meg_a: assert property (
    mode_sync == md_adv_1m |=> data_addr[23:20] == 4'h0)
    else $error("upper address bits kept in 1-Mbyte mode");
  normal_64k_a: assert property (
    mode_sync == md_normal && $stable(mode_sync) |=>
      data_addr[23:16] == 8'h00)
    else $error("normal mode address above 64 kbytes");
endmodule : cpr_regfile

// [dv/cpu_register_and_flag_state_tb_top.sv]
// bench of the cpu state block: registers, stack, pc, flags, addresses
// assumes: the package and cpr_regfile are compiled before this file
`timescale 1ns/100ps
module cpu_register_and_flag_state_tb_top;
  import cpr_pkg::*;
  logic core_clk = 0, rst_n = 0, reset_exc = 0, exc_start = 0;
  logic pc_load = 0, pc_inc = 0, wr_en = 0;
  logic [23:0] reset_vector = 0, pc_target = 0, ea = 0;
  logic [3:0]  pc_step = 0, br_cond = 4'h7;
  logic [31:0] wr_data = 0, rd_data, alu_result, d, w;
  cpr_mode_t cpu_mode = md_adv_16m;
  cpr_sel_t wr_sel = '0, rd_sel = '0;
  cpr_alu_req_t alu_req = '0;
  cpr_sp_op_t sp_op = sp_none;
  cpr_size_t sp_size = sz_long, ea_size = sz_word;
  logic alu_done, branch_true;
  logic [23:0] stack_addr, program_counter, fetch_addr, data_addr;
  cpr_flags_t condition_flags;
  int errors = 0, n_tests = 0;
  always #2 core_clk = ~core_clk;
  cpr_regfile dut (.core_clk, .rst_n, .cpu_mode, .reset_exc,
    .reset_vector, .exc_start, .pc_load, .pc_target, .pc_inc, .pc_step,
    .wr_en, .wr_sel, .wr_data, .rd_sel, .alu_req, .sp_op, .sp_size,
    .br_cond, .ea, .ea_size, .rd_data, .alu_result, .alu_done,
    .stack_addr, .program_counter, .fetch_addr, .data_addr,
    .condition_flags, .branch_true);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wreg(input logic [2:0] i, cpr_size_t s, logic u,
                      logic [31:0] v);
    wr_en = 1;
    wr_sel = '{i, s, u};
    wr_data = v;
    tick;
    wr_en = 0;
  endtask : wreg
  task automatic rreg(input logic [2:0] i, cpr_size_t s, logic u,
                      logic [31:0] e);
    rd_sel = '{i, s, u};
    tick;
    chk(rd_data, e);
  endtask : rreg
  // expected {flags, result} of add or subtract at the given size
  function automatic logic [39:0] model(input cpr_op_t op, cpr_size_t s,
                                        logic [31:0] a, logic [31:0] b);
    int w;
    logic [32:0] m, hm, am, bm, r, hr;
    logic sb, v;
    w = s == sz_byte ? 8 : s == sz_word ? 16 : 32;
    sb = op == op_sub;
    m = (33'h1 << w) - 1;
    hm = (33'h1 << (w - 4)) - 1;
    am = a & m;
    bm = b & m;
    r = sb ? am - bm : am + bm;
    hr = sb ? (am & hm) - (bm & hm) : (am & hm) + (bm & hm);
    v = (am[w-1] ^ r[w-1]) & (sb ^ ~(am[w-1] ^ bm[w-1]));
    return {4'h8 | {2'b00, hr[w-4], 1'b0}, r[w-1], (r & m) == 0, v, r[w],
            r[31:0] & m[31:0]};
  endfunction : model
  task automatic alu(input cpr_op_t op, cpr_size_t s, logic [31:0] a,
                     logic [31:0] b);
    logic [39:0] e;
    e = model(op, s, a, b);
    alu_req = '0;
    alu_req.valid = 1;
    alu_req.op = op;
    alu_req.size = s;
    alu_req.a = a;
    alu_req.b = b;
    tick;
    alu_req.valid = 0;
    chk(alu_done, 1);
    chk(alu_result, e[31:0]);
    chk(condition_flags, e[39:32]);
    tick;
    chk(alu_done, 0);
    chk(branch_true, e[34]);
  endtask : alu
  // one byte flag op, flag register checked a cycle later
  task automatic flg(input cpr_op_t op, logic [31:0] a, logic [2:0] n,
                     logic [7:0] e);
    alu_req = '{1'b1, op, sz_byte, a, 32'h0, n, 1'b0, 1'b0, '0};
    tick;
    alu_req.valid = 0;
    chk(condition_flags, e);
    tick;
  endtask : flg
  initial begin
    void'($urandom(32'he00d10b1));
    repeat (4) @(posedge core_clk);
    #1;
    rst_n = 1;
    chk(condition_flags, 8'h80);
    reset_vector = 24'h012345;
    reset_exc = 1;
    tick;
    reset_exc = 0;
    chk(program_counter, 24'h012345);
    chk(fetch_addr, 24'h012344);
    pc_step = 4'h2;
    pc_inc = 1;
    tick;
    pc_inc = 0;
    chk(program_counter, 24'h012347);
    for (int k = 0; k < 8; k++) begin
      d = $urandom;
      w = $urandom;
      wreg(k, sz_long, 0, d);
      rreg(k, sz_long, 0, d);
      wreg(k, sz_word, 1, w);
      rreg(k, sz_long, 0, {w[15:0], d[15:0]});
      wreg(k, sz_byte, 1, w);
      rreg(k, sz_word, 0, {16'h0, w[7:0], d[7:0]});
      rreg(k, sz_byte, 0, {24'h0, d[7:0]});
    end
    wreg(7, sz_long, 0, 32'h1000);
    sp_op = sp_push;
    tick;
    sp_op = sp_pop;
    chk(stack_addr, 24'h000FFC);
    sp_size = sz_word;
    tick;
    sp_op = sp_none;
    chk(stack_addr, 24'h000FFC);
    rreg(7, sz_long, 0, 32'h0FFE);
    alu(op_add, sz_byte, 32'h0F, 32'h01);
    alu(op_add, sz_byte, 32'h80, 32'h80);
    alu(op_sub, sz_word, 32'h0, 32'h1);
    alu(op_add, sz_long, 32'h0FFFFFFF, 32'h1);
    repeat (30) alu($urandom_range(1) ? op_add : op_sub,
                    cpr_size_t'($urandom_range(2)), $urandom, $urandom);
    flg(op_ldc, 32'h5A, 0, 8'h5A);
    exc_start = 1;
    tick;
    exc_start = 0;
    chk(condition_flags, 8'hDA);
    flg(op_and_flags_instr, 32'h7E, 0, 8'h5A);
    flg(op_bit_load, 32'h10, 4, 8'h5B);
    flg(op_nop, 32'h0, 0, 8'h5B);
    flg(op_bit_and, 32'h10, 3, 8'h5A);
    exc_start = 1;
    flg(op_ldc, 32'h00, 0, 8'h80);
    exc_start = 0;
    ea = 24'hABCDEF;
    for (int m = 0; m < 3; m++) begin
      cpu_mode = cpr_mode_t'(m);
      repeat (4) tick;
      chk(data_addr, m == 0 ? 24'h00CDEE : m == 1 ? 24'h0BCDEE
                                     : 24'hABCDEE);
    end
    ea_size = sz_byte;
    repeat (2) tick;
    chk(data_addr, 24'hABCDEF);
    report_and_stop;
  end
  initial begin
    #20000;
    errors++;
    report_and_stop;
  end
endmodule : cpu_register_and_flag_state_tb_top
